// file: rtl/dcbsl_core.sv
// command decode, power state and per-bank state logic of the dram
`timescale 1ns/10ps
module dcbsl_core
  import dcbsl_pkg::*;
#(
  parameter logic [TIMER_BITS-1:0] PRECHARGE_CYCLES       = 8'h03,
  parameter logic [TIMER_BITS-1:0] ACTIVATE_CYCLES        = 8'h03,
  parameter logic [TIMER_BITS-1:0] ROW_CYCLE_CYCLES       = 8'h0a,
  parameter logic [TIMER_BITS-1:0] MODE_REG_CYCLES        = 8'h02,
  parameter logic [TIMER_BITS-1:0] BURST_CYCLES           = 8'h02,
  parameter logic [TIMER_BITS-1:0] SELF_REFRESH_EXIT_CYCLES = 8'h10
) (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic                 link_clock,
  input  wire logic                 clock_enable,
  input  wire logic                 chip_select_n,
  input  wire logic                 row_strobe_n,
  input  wire logic                 column_strobe_n,
  input  wire logic                 write_enable_n,
  input  wire logic                 all_bank_select_address_bit,
  input  wire logic [BANK_BITS-1:0] bank_select_bits,
  output logic [1:0]                power_state,
  output logic [NUM_BANKS-1:0]      bank_open,
  output logic [NUM_BANKS-1:0]      bank_idle,
  output logic                      command_accepted,
  output logic                      command_illegal,
  output logic                      termination_disable
);
  // link reset: reset crosses into the link domain via two flops
  logic link_reset_meta;
  logic link_reset;
  always_ff @(posedge link_clock) begin
    link_reset_meta <= reset;
    link_reset      <= link_reset_meta;
  end

  // command pins are sampled on the link clock edge, as the controller drives them there
  logic       cke_now;
  logic       cke_prev;
  logic [3:0] pins;
  logic       ap_bit;
  logic [BANK_BITS-1:0] bank_sel;
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      cke_now  <= 1'b0;
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= cke_now;
      cke_now  <= clock_enable;
    end
  end
  always_ff @(posedge link_clock) begin
    pins     <= {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
    ap_bit   <= all_bank_select_address_bit;
    bank_sel <= bank_select_bits;
  end

  dcbsl_cmd_type cmd;
  always_comb begin
    if (pins[3]) begin
      cmd = DCBSL_CMD_DESELECT;
    end else begin
      unique case (pins)
        CMD_NOP:       cmd = DCBSL_CMD_NOP;
        CMD_ACTIVATE:  cmd = DCBSL_CMD_ACTIVATE;
        CMD_REFRESH:   cmd = DCBSL_CMD_REFRESH;
        CMD_LOAD_MODE: cmd = DCBSL_CMD_LOAD_MODE;
        CMD_READ:      cmd = DCBSL_CMD_READ;
        CMD_WRITE:     cmd = DCBSL_CMD_WRITE;
        CMD_PRECHARGE: cmd = DCBSL_CMD_PRECHARGE;
        default:       cmd = DCBSL_CMD_NOP;
      endcase
    end
  end
  logic is_idle_cmd;
  assign is_idle_cmd = (cmd == DCBSL_CMD_DESELECT) || (cmd == DCBSL_CMD_NOP);

  // bank states
  dcbsl_bank_type state [NUM_BANKS];
  logic [NUM_BANKS-1:0] idle_vec;
  logic [NUM_BANKS-1:0] open_vec;
  logic [NUM_BANKS-1:0] busy_vec;
  logic all_idle;
  assign all_idle = &idle_vec;

  dcbsl_pwr_type pwr;
  logic [TIMER_BITS-1:0] exit_timer;
  logic cmd_window;
  // command table applies only with enable high on both edges and exit delay met
  assign cmd_window = cke_prev && cke_now && (exit_timer == '0);

  logic [NUM_BANKS-1:0] do_act, do_rd, do_wr, do_pre, do_ref, do_lmr, hit, legal;
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      assign idle_vec[b] = (state[b] == DCBSL_BANK_IDLE);
      assign busy_vec[b] = (state[b] == DCBSL_BANK_READ) || (state[b] == DCBSL_BANK_WRITE);
      assign open_vec[b] = (state[b] == DCBSL_BANK_ROW_ACTIVE) || busy_vec[b];
      // precharge hits all banks when the all-bank bit is set
      assign hit[b] = (cmd == DCBSL_CMD_PRECHARGE && ap_bit)
                      || (bank_sel == BANK_BITS'(b));
      always_comb begin
        legal[b] = 1'b0;
        unique case (cmd)
          DCBSL_CMD_ACTIVATE:
            legal[b] = hit[b] && idle_vec[b];
          DCBSL_CMD_REFRESH, DCBSL_CMD_LOAD_MODE:
            legal[b] = all_idle;
          DCBSL_CMD_READ:
            legal[b] = hit[b] && open_vec[b];
          DCBSL_CMD_WRITE:
            legal[b] = hit[b] && (state[b] == DCBSL_BANK_ROW_ACTIVE
                                  || state[b] == DCBSL_BANK_WRITE);
          DCBSL_CMD_PRECHARGE:
            legal[b] = hit[b] && (state[b] == DCBSL_BANK_ROW_ACTIVE || idle_vec[b]);
          default:
            legal[b] = 1'b0;
        endcase
      end
      assign do_act[b] = cmd_window && cmd == DCBSL_CMD_ACTIVATE  && legal[b];
      assign do_rd[b]  = cmd_window && cmd == DCBSL_CMD_READ      && legal[b];
      assign do_wr[b]  = cmd_window && cmd == DCBSL_CMD_WRITE     && legal[b];
      assign do_pre[b] = cmd_window && cmd == DCBSL_CMD_PRECHARGE && legal[b]
                         && !idle_vec[b];
      assign do_ref[b] = cmd_window && cmd == DCBSL_CMD_REFRESH   && legal[b];
      assign do_lmr[b] = cmd_window && cmd == DCBSL_CMD_LOAD_MODE && legal[b];
      dcbsl_bank #(
        .PRECHARGE_CYCLES (PRECHARGE_CYCLES),
        .ACTIVATE_CYCLES  (ACTIVATE_CYCLES),
        .ROW_CYCLE_CYCLES (ROW_CYCLE_CYCLES),
        .MODE_REG_CYCLES  (MODE_REG_CYCLES),
        .BURST_CYCLES     (BURST_CYCLES)
      ) u_bank (
        .link_clock     (link_clock),
        .link_reset     (link_reset),
        .do_activate    (do_act[b]),
        .do_read        (do_rd[b]),
        .do_write       (do_wr[b]),
        .auto_precharge (ap_bit),
        .do_precharge   (do_pre[b]),
        .do_refresh     (do_ref[b]),
        .do_load_mode   (do_lmr[b]),
        .state          (state[b])
      );
    end
  endgenerate

  // power state machine; illegal enable sequences simply hold the state
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      pwr <= DCBSL_PWR_ACTIVE;
    end else begin
      unique case (pwr)
        DCBSL_PWR_ACTIVE: begin
          if (cke_prev && !cke_now && is_idle_cmd) begin
            pwr <= all_idle ? DCBSL_PWR_PRECHARGE_PD
                            : DCBSL_PWR_ACTIVE_PD;
          end else if (cke_prev && !cke_now && cmd == DCBSL_CMD_REFRESH && all_idle) begin
            pwr <= DCBSL_PWR_SELF_REFRESH;
          end
        end
        DCBSL_PWR_PRECHARGE_PD, DCBSL_PWR_ACTIVE_PD: begin
          if (!cke_prev && cke_now && is_idle_cmd) begin
            pwr <= DCBSL_PWR_ACTIVE;
          end
        end
        DCBSL_PWR_SELF_REFRESH: begin
          if (!cke_prev && cke_now && is_idle_cmd) begin
            pwr <= DCBSL_PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  // exit delay counted after self refresh ends
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      exit_timer <= '0;
    end else if (pwr == DCBSL_PWR_SELF_REFRESH && !cke_prev && cke_now && is_idle_cmd) begin
      exit_timer <= SELF_REFRESH_EXIT_CYCLES;
    end else if (exit_timer != '0) begin
      exit_timer <= exit_timer - 8'h01;
    end
  end

  // link-side status flops, crossed by two-flop synchronisers to the core clock
  logic [1:0]           l_pwr;
  logic [NUM_BANKS-1:0] l_open, l_idle;
  logic                 l_acc_tog, l_ill_tog, l_term;
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      l_pwr     <= 2'b00;
      l_open    <= '0;
      l_idle    <= '1;
      l_acc_tog <= 1'b0;
      l_ill_tog <= 1'b0;
      l_term    <= 1'b0;
    end else begin
      l_pwr  <= pwr;
      l_open <= open_vec;
      l_idle <= idle_vec;
      l_term <= (pins[2:0] == STROBE_TERM_DISABLE);
      if (cmd_window && !is_idle_cmd && pwr == DCBSL_PWR_ACTIVE) begin
        if (|legal) begin
          l_acc_tog <= ~l_acc_tog;
        end else begin
          l_ill_tog <= ~l_ill_tog;
        end
      end
    end
  end

  // termination level rides the same two-flop chain as the other status
  logic [12:0] sync_a, sync_b;
  logic        acc_seen, ill_seen;
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {l_term, l_pwr, l_open, l_idle, l_acc_tog, l_ill_tog};
      sync_b <= sync_a;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      power_state         <= 2'b00;
      bank_open           <= '0;
      bank_idle           <= '0;
      command_accepted    <= 1'b0;
      command_illegal     <= 1'b0;
      termination_disable <= 1'b0;
      acc_seen            <= 1'b0;
      ill_seen            <= 1'b0;
    end else begin
      power_state         <= sync_b[11:10];
      bank_open           <= sync_b[9:6];
      bank_idle           <= sync_b[5:2];
      acc_seen            <= sync_b[1];
      ill_seen            <= sync_b[0];
      command_accepted    <= sync_b[1] ^ acc_seen;
      command_illegal     <= sync_b[0] ^ ill_seen;
      termination_disable <= sync_b[12];
    end
  end

  property p_self_refresh_entry;
    @(posedge link_clock) disable iff (link_reset)
      (pwr == DCBSL_PWR_ACTIVE && cke_prev && !cke_now && cmd == DCBSL_CMD_REFRESH && all_idle)
      |=> pwr == DCBSL_PWR_SELF_REFRESH;
  endproperty
  a_self_refresh_entry: assert property (p_self_refresh_entry)
    else $error("self refresh not entered");
  property p_pd_hold;
    @(posedge link_clock) disable iff (link_reset)
      (pwr != DCBSL_PWR_ACTIVE && !cke_prev && !cke_now) |=> pwr == $past(pwr);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("power-down not held");
  property p_no_cmd_in_exit;
    @(posedge link_clock) disable iff (link_reset)
      (exit_timer != '0) |-> (do_act == '0 && do_rd == '0 && do_wr == '0);
  endproperty
  a_no_cmd_in_exit: assert property (p_no_cmd_in_exit)
    else $error("command accepted inside exit delay");
  property p_precharge_pd_entry;
    @(posedge link_clock) disable iff (link_reset)
      (pwr == DCBSL_PWR_ACTIVE && cke_prev && !cke_now && is_idle_cmd && all_idle)
      |=> pwr == DCBSL_PWR_PRECHARGE_PD;
  endproperty
  a_precharge_pd_entry: assert property (p_precharge_pd_entry)
    else $error("precharge power-down not entered");
  property p_active_pd_entry;
    @(posedge link_clock) disable iff (link_reset)
      (pwr == DCBSL_PWR_ACTIVE && cke_prev && !cke_now && is_idle_cmd && !all_idle)
      |=> pwr == DCBSL_PWR_ACTIVE_PD;
  endproperty
  a_active_pd_entry: assert property (p_active_pd_entry)
    else $error("active power-down not entered");
  property p_pd_exit;
    @(posedge link_clock) disable iff (link_reset)
      ((pwr == DCBSL_PWR_PRECHARGE_PD || pwr == DCBSL_PWR_ACTIVE_PD)
       && !cke_prev && cke_now && is_idle_cmd)
      |=> pwr == DCBSL_PWR_ACTIVE;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("power-down not left");
  property p_sr_exit;
    @(posedge link_clock) disable iff (link_reset)
      (pwr == DCBSL_PWR_SELF_REFRESH && !cke_prev && cke_now && is_idle_cmd)
      |=> (pwr == DCBSL_PWR_ACTIVE && exit_timer == SELF_REFRESH_EXIT_CYCLES);
  endproperty
  a_sr_exit: assert property (p_sr_exit)
    else $error("self refresh not left");
endmodule

// file: rtl/dcbsl_pkg.sv
// shared constants and types for the dram command and bank state logic
package dcbsl_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_BITS = 2;
  localparam int TIMER_BITS = 8;
  // command pin patterns {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP       = 4'h7;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [2:0] STROBE_TERM_DISABLE = 3'h5;
  localparam int AUTO_PRECHARGE_BIT = 8;

  typedef enum logic [2:0] {
    DCBSL_CMD_DESELECT  = 3'b000,
    DCBSL_CMD_NOP       = 3'b001,
    DCBSL_CMD_ACTIVATE  = 3'b010,
    DCBSL_CMD_REFRESH   = 3'b011,
    DCBSL_CMD_LOAD_MODE = 3'b100,
    DCBSL_CMD_READ      = 3'b101,
    DCBSL_CMD_WRITE     = 3'b110,
    DCBSL_CMD_PRECHARGE = 3'b111
  } dcbsl_cmd_type;

  typedef enum logic [1:0] {
    DCBSL_PWR_ACTIVE        = 2'b00,
    DCBSL_PWR_PRECHARGE_PD  = 2'b01,
    DCBSL_PWR_ACTIVE_PD     = 2'b10,
    DCBSL_PWR_SELF_REFRESH  = 2'b11
  } dcbsl_pwr_type;

  typedef enum logic [3:0] {
    DCBSL_BANK_IDLE         = 4'b0000,
    DCBSL_BANK_ACTIVATING   = 4'b0001,
    DCBSL_BANK_ROW_ACTIVE   = 4'b0010,
    DCBSL_BANK_READ         = 4'b0011,
    DCBSL_BANK_WRITE        = 4'b0100,
    DCBSL_BANK_READ_AP      = 4'b0101,
    DCBSL_BANK_WRITE_AP     = 4'b0110,
    DCBSL_BANK_PRECHARGING  = 4'b0111,
    DCBSL_BANK_REFRESHING   = 4'b1000,
    DCBSL_BANK_MODE_ACCESS  = 4'b1001
  } dcbsl_bank_type;
endpackage

// file: rtl/dcbsl_bank.sv
// one bank state machine with its own delay timer
`timescale 1ns/10ps
module dcbsl_bank
  import dcbsl_pkg::*;
#(
  parameter logic [TIMER_BITS-1:0] PRECHARGE_CYCLES  = 8'h03,
  parameter logic [TIMER_BITS-1:0] ACTIVATE_CYCLES   = 8'h03,
  parameter logic [TIMER_BITS-1:0] ROW_CYCLE_CYCLES  = 8'h0a,
  parameter logic [TIMER_BITS-1:0] MODE_REG_CYCLES   = 8'h02,
  parameter logic [TIMER_BITS-1:0] BURST_CYCLES      = 8'h02
) (
  input  wire logic           link_clock,
  input  wire logic           link_reset,
  input  wire logic           do_activate,
  input  wire logic           do_read,
  input  wire logic           do_write,
  input  wire logic           auto_precharge,
  input  wire logic           do_precharge,
  input  wire logic           do_refresh,
  input  wire logic           do_load_mode,
  output dcbsl_bank_type      state
);
  logic [TIMER_BITS-1:0] timer;
  logic                  expired;
  assign expired = (timer == '0);

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      state <= DCBSL_BANK_IDLE;
      timer <= '0;
    end else if (do_refresh) begin
      state <= DCBSL_BANK_REFRESHING;
      timer <= ROW_CYCLE_CYCLES - 8'h01;
    end else if (do_load_mode) begin
      state <= DCBSL_BANK_MODE_ACCESS;
      timer <= MODE_REG_CYCLES - 8'h01;
    end else if (do_activate) begin
      state <= DCBSL_BANK_ACTIVATING;
      timer <= ACTIVATE_CYCLES - 8'h01;
    end else if (do_read || do_write) begin
      // auto precharge covers the burst and the precharge time in one count
      if (auto_precharge) begin
        state <= do_read ? DCBSL_BANK_READ_AP : DCBSL_BANK_WRITE_AP;
        timer <= BURST_CYCLES + PRECHARGE_CYCLES - 8'h01;
      end else begin
        state <= do_read ? DCBSL_BANK_READ : DCBSL_BANK_WRITE;
        timer <= BURST_CYCLES - 8'h01;
      end
    end else if (do_precharge) begin
      state <= DCBSL_BANK_PRECHARGING;
      timer <= PRECHARGE_CYCLES - 8'h01;
    end else begin
      if (!expired) begin
        timer <= timer - 8'h01;
      end
      if (expired) begin
        unique case (state)
          DCBSL_BANK_ACTIVATING, DCBSL_BANK_READ, DCBSL_BANK_WRITE: begin
            state <= DCBSL_BANK_ROW_ACTIVE;
          end
          DCBSL_BANK_PRECHARGING, DCBSL_BANK_READ_AP, DCBSL_BANK_WRITE_AP,
          DCBSL_BANK_REFRESHING, DCBSL_BANK_MODE_ACCESS: begin
            state <= DCBSL_BANK_IDLE;
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end
endmodule

// file: tb/dcbsl_ctrl_model.sv
// memory controller model driving the command pins on the link clock
`timescale 1ns/10ps
module dcbsl_ctrl_model
  import dcbsl_pkg::*;
#(
  parameter int SR_EXIT_WAIT = 18
) (
  input  wire logic            link_clock,
  output logic                 clock_enable,
  output logic                 chip_select_n,
  output logic                 row_strobe_n,
  output logic                 column_strobe_n,
  output logic                 write_enable_n,
  output logic                 all_bank_select_address_bit,
  output logic [BANK_BITS-1:0] bank_select_bits
);
  int   hold_off = 0;
  logic in_sr    = 1'b0;

  initial begin
    clock_enable = 1'b1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = CMD_NOP;
    all_bank_select_address_bit = 1'b0;
    bank_select_bits = 2'h0;
  end

  // one command for one link cycle, then nop filler
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank, input logic a8,
                       input logic cke);
    if (cke && clock_enable && cmd[3] == 1'b0 && cmd != CMD_NOP) begin
      repeat (hold_off) @(posedge link_clock);
      hold_off = 0;
    end
    @(posedge link_clock);
    #1;
    if (!clock_enable && cke) hold_off = in_sr ? SR_EXIT_WAIT : 6;
    if (clock_enable && !cke) in_sr = (cmd == CMD_REFRESH);
    clock_enable = cke;
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = cmd;
    all_bank_select_address_bit = a8;
    bank_select_bits = bank;
    @(posedge link_clock);
    #1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = CMD_NOP;
    // address lines no longer hold the last value once the command is gone
    all_bank_select_address_bit = ~a8;
    bank_select_bits = ~bank;
  endtask
endmodule

// file: tb/dcbsl_core_test.sv
// self-checking bench for the dram command and bank state logic
`timescale 1ns/10ps
module dcbsl_core_test;
  import dcbsl_pkg::*;
  localparam logic [TIMER_BITS-1:0] SR_EXIT = 8'h10;
  logic                 clock      = 1'b0;
  logic                 reset      = 1'b1;
  logic                 link_clock = 1'b0;
  logic                 clock_enable;
  logic                 chip_select_n;
  logic                 row_strobe_n;
  logic                 column_strobe_n;
  logic                 write_enable_n;
  logic                 all_bank_select_address_bit;
  logic [BANK_BITS-1:0] bank_select_bits;
  logic [1:0]           power_state;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] bank_idle;
  logic                 command_accepted;
  logic                 command_illegal;
  logic                 termination_disable;
  int                   fail_count = 0;
  int                   checks     = 0;
  int                   acc_n      = 0;
  int                   ill_n      = 0;

  initial forever #2.5 clock = ~clock;
  // link clock free running, phase unrelated to the core clock
  initial begin
    #7;
    forever #24 link_clock = ~link_clock;
  end

  dcbsl_ctrl_model #(.SR_EXIT_WAIT(int'(SR_EXIT) + 2)) u_ctrl (
    .link_clock(link_clock), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_enable_n(write_enable_n), .all_bank_select_address_bit(all_bank_select_address_bit),
    .bank_select_bits(bank_select_bits));

  dcbsl_core #(.PRECHARGE_CYCLES(8'h03), .ACTIVATE_CYCLES(8'h03), .ROW_CYCLE_CYCLES(8'h0a),
    .MODE_REG_CYCLES(8'h02), .BURST_CYCLES(8'h02), .SELF_REFRESH_EXIT_CYCLES(SR_EXIT)) u_dut (
    .clock(clock), .reset(reset), .link_clock(link_clock), .clock_enable(clock_enable),
    .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
    .all_bank_select_address_bit(all_bank_select_address_bit),
    .bank_select_bits(bank_select_bits), .power_state(power_state), .bank_open(bank_open),
    .bank_idle(bank_idle), .command_accepted(command_accepted),
    .command_illegal(command_illegal), .termination_disable(termination_disable));

  // pulses last one core cycle, so they are counted as they pass
  always @(posedge clock) begin
    if (command_accepted === 1'b1) acc_n++;
    if (command_illegal === 1'b1) ill_n++;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // bank state moves one link edge after decode, status one edge later
  task automatic settle();
    repeat (2) @(posedge link_clock);
    repeat (5) @(posedge clock);
  endtask

  task automatic wait_state(input logic [1:0] pw, input logic [3:0] op, input logic [3:0] id);
    int n;
    n = 0;
    settle();
    while (n < 400 && !(power_state === pw && bank_open === op && bank_idle === id)) begin
      @(posedge clock);
      n++;
    end
    check("power_state", 8'(power_state), 8'(pw));
    check("bank_open", 8'(bank_open), 8'(op));
    check("bank_idle", 8'(bank_idle), 8'(id));
    if (n >= 400) report_and_stop();
  endtask

  task automatic t_activate();
    int a;
    a = acc_n;
    u_ctrl.issue(CMD_ACTIVATE, 2'h1, 1'b0, 1'b1);
    u_ctrl.issue(4'h8, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h2, 4'hd);
    check("accepted", 8'(acc_n - a), 8'h01);
  endtask

  task automatic t_burst();
    u_ctrl.issue(CMD_READ, 2'h1, 1'b1, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
    u_ctrl.issue(CMD_ACTIVATE, 2'h2, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h4, 4'hb);
    u_ctrl.issue(CMD_WRITE, 2'h2, 1'b0, 1'b1);
    u_ctrl.issue(CMD_WRITE, 2'h2, 1'b0, 1'b1);
    u_ctrl.issue(CMD_READ, 2'h2, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h4, 4'hb);
  endtask

  task automatic t_precharge();
    u_ctrl.issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h5, 4'ha);
    u_ctrl.issue(CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h4, 4'hb);
    u_ctrl.issue(CMD_PRECHARGE, 2'h0, 1'b1, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
  endtask

  task automatic t_power_down();
    u_ctrl.issue(CMD_ACTIVATE, 2'h3, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h8, 4'h7);
    u_ctrl.issue(CMD_NOP, 2'h0, 1'b0, 1'b0);
    wait_state(DCBSL_PWR_ACTIVE_PD, 4'h8, 4'h7);
    u_ctrl.issue(CMD_PRECHARGE, 2'h3, 1'b0, 1'b0);
    wait_state(DCBSL_PWR_ACTIVE_PD, 4'h8, 4'h7);
    u_ctrl.issue(CMD_NOP, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h8, 4'h7);
    u_ctrl.issue(CMD_PRECHARGE, 2'h3, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
    u_ctrl.issue(4'h8, 2'h0, 1'b0, 1'b0);
    wait_state(DCBSL_PWR_PRECHARGE_PD, 4'h0, 4'hf);
    u_ctrl.issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b0);
    wait_state(DCBSL_PWR_PRECHARGE_PD, 4'h0, 4'hf);
    u_ctrl.issue(4'h8, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
  endtask

  task automatic t_self_refresh();
    u_ctrl.issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0);
    wait_state(DCBSL_PWR_SELF_REFRESH, 4'h0, 4'hf);
    u_ctrl.issue(CMD_ACTIVATE, 2'h1, 1'b0, 1'b0);
    wait_state(DCBSL_PWR_SELF_REFRESH, 4'h0, 4'hf);
    u_ctrl.issue(CMD_NOP, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
    u_ctrl.issue(CMD_ACTIVATE, 2'h1, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h2, 4'hd);
    u_ctrl.issue(CMD_PRECHARGE, 2'h1, 1'b1, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
  endtask

  task automatic t_misc();
    int a;
    int i;
    a = ill_n;
    u_ctrl.issue(CMD_READ, 2'h3, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
    check("illegal", 8'(ill_n - a), 8'h01);
    a = acc_n;
    u_ctrl.issue(CMD_REFRESH, 2'h0, 1'b0, 1'b1);
    settle();
    check("refreshing", 8'(bank_idle), 8'h00);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
    u_ctrl.issue(CMD_LOAD_MODE, 2'h0, 1'b0, 1'b1);
    wait_state(DCBSL_PWR_ACTIVE, 4'h0, 4'hf);
    check("accepted", 8'(acc_n - a), 8'h02);
    u_ctrl.issue({1'b1, STROBE_TERM_DISABLE}, 2'h0, 1'b0, 1'b1);
    // level stands one link cycle only, so watch from the issue on
    i = 0;
    while (i < 40 && termination_disable !== 1'b1) begin
      @(posedge clock);
      i++;
    end
    check("termination_disable", 8'(termination_disable), 8'h01);
  endtask

  initial begin
    // reset spans more than four link cycles so the link side sees it
    repeat (45) @(posedge clock);
    #1;
    reset = 1'b0;
    repeat (6) @(posedge link_clock);
    t_activate();
    t_burst();
    t_precharge();
    t_power_down();
    t_self_refresh();
    t_misc();
    report_and_stop();
  end

  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule
